//--- include/dpa_pkg.sv
// Shared constants, types and helpers of the DMA request priority arbiter
package dpa_pkg;
	localparam int NUM_CHAN = 4;
	localparam int NUM_EXT = 2;
	localparam int NUM_PSRC = 5;
	localparam int AXI_AW = 8;
	localparam logic [7:0] OFS_CHAN0 = 8'h00;
	localparam logic [7:0] OFS_CHAN1 = 8'h04;
	localparam logic [7:0] OFS_CHAN2 = 8'h08;
	localparam logic [7:0] OFS_CHAN3 = 8'h0c;
	localparam logic [7:0] OFS_OPER = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] OFS_PREN = 8'h18;
	localparam int OPER_ME_BIT = 0;
	localparam int OPER_NMI_BIT = 1;
	localparam int OPER_AE_BIT = 2;
	localparam int OPER_PRIO_LSB = 8;
	localparam logic [3:0] SRC_EXT_DUAL = 4'h0;
	localparam logic [3:0] SRC_EXT_MEM2DEV = 4'h2;
	localparam logic [3:0] SRC_EXT_DEV2MEM = 4'h3;
	localparam logic [3:0] SRC_AUTO = 4'h4;
	localparam logic [3:0] SRC_PERIPH_BASE = 4'h8;
	localparam logic [3:0] SRC_CAP_LAST = 4'he;
	localparam int PSRC_CAP = 4;
	localparam logic [1:0] PRIO_FIX0 = 2'h0;
	localparam logic [1:0] PRIO_FIX1 = 2'h1;
	localparam logic [1:0] PRIO_FIX2 = 2'h2;
	localparam logic [1:0] PRIO_RR = 2'h3;
	localparam logic [1:0] RR_TOP_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic xfer_end_flag;
		logic chan_enable;
		logic burst_mode;
		logic req_detect_sel;
		logic [3:0] req_source_sel;
	} dpa_chan_ctrl_type;

	typedef struct packed {
		logic [1:0] prio_sel;
		logic addr_err_flag;
		logic nmi_flag;
		logic master_enable;
	} dpa_oper_type;

	typedef struct packed {
		logic capture_req_en_hi;
		logic capture_req_en_lo;
		logic [3:0] serial_en;
	} dpa_pren_type;

	typedef enum {ST_IDLE, ST_BUSY} dpa_state_type;

	localparam dpa_chan_ctrl_type CHAN_CTRL_RST = 8'h00;
	localparam dpa_oper_type OPER_RST = 5'h00;
	localparam dpa_pren_type PREN_RST = 6'h00;

	function automatic logic is_serial(input logic [3:0] src);
		is_serial = (src[3:2] == 2'h2);
	endfunction : is_serial

	function automatic logic is_capture(input logic [3:0] src);
		is_capture = (src[3:2] == 2'h3) && (src <= SRC_CAP_LAST);
	endfunction : is_capture

	function automatic logic is_ext(input logic [3:0] src);
		is_ext = (src == SRC_EXT_DUAL) || (src == SRC_EXT_MEM2DEV) ||
			(src == SRC_EXT_DEV2MEM);
	endfunction : is_ext

	// Channel that holds a given rank (0 = highest) under a priority mode
	function automatic logic [1:0] prio_chan(input logic [1:0] sel,
		input logic [1:0] rr_top, input logic [1:0] rank);
		logic [7:0] tab;
		tab = 8'he4;
		unique case (sel)
			PRIO_FIX0: tab = 8'he4;
			PRIO_FIX1: tab = 8'h78;
			PRIO_FIX2: tab = 8'hd2;
			PRIO_RR: tab = 8'he4;
		endcase
		if (sel == PRIO_RR)
			prio_chan = 2'(rr_top + rank);
		else
			prio_chan = tab[{rank, 1'b0} +: 2];
	endfunction : prio_chan
endpackage : dpa_pkg

//--- hw/dpa_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dpa_pin_sync (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pin,
	output logic level
);
	logic ff1;
	logic ff2;
	logic ff3;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ff1 <= 1'b1;
			ff2 <= 1'b1;
			ff3 <= 1'b1;
		end else begin
			ff1 <= pin;
			ff2 <= ff1;
			ff3 <= ff2;
		end
	end

	// Level changes only once stages two and three agree
	always_ff @(posedge clk) begin
		if (!reset_n)
			level <= 1'b1;
		else if (ff2 == ff3)
			level <= ff3;
	end
endmodule : dpa_pin_sync
`default_nettype wire

//--- hw/dpa_arbiter.sv
// Combinational channel selector over the active priority order
`timescale 1ns/1ps
`default_nettype none
module dpa_arbiter
	import dpa_pkg::*;
(
	input wire logic [3:0] req,
	input wire logic [1:0] prio_sel,
	input wire logic [1:0] rr_top,
	output logic win_valid,
	output logic [1:0] win_chan
);
	logic [1:0] c;

	always_comb begin
		c = 2'h0;
		win_valid = 1'b0;
		win_chan = 2'h0;
		// Walk from lowest rank up so the highest rank wins last
		for (int r = NUM_CHAN - 1; r >= 0; r--) begin
			c = prio_chan(prio_sel, rr_top, 2'(r));
			if (req[c]) begin
				win_valid = 1'b1;
				win_chan = c;
			end
		end
	end
endmodule : dpa_arbiter
`default_nettype wire

//--- hw/dpa_core.sv
// DMA request source handling and channel priority arbitration
// Behaviour
// - External request pin is recognised as a low level or a falling edge.
// - Detect-select 0 means level detection, 1 means falling-edge detection.
// - Edge request latched while channel is idle but flags clear, until served.
// - Five peripheral requests: capture plus receive/transmit of two serial units.
// - Transfer starts only when both enables set and all three flags clear.
// - Request source is independent of data source and destination.
// - Serial receive requests move data in cycle-steal mode only.
// - One capture event is served only by the highest-priority channel.
// - Capture request withdrawn when both capture enable bits are 0.
// - Peripheral request only passes while its own enable bit is set.
// - Served peripheral request clears per unit, or at the last in burst.
// - Simultaneous requests granted by fixed or round-robin order.
// - Fixed orders are 0123, 0231 and 2013, highest first.
// - In round robin a channel finishing a unit drops to lowest.
// - Demotion rotates the order, followers keep their relative order.
// - Round-robin order after reset is 0, 1, 2, 3.
// - No other request accepted during a transfer resets order to 0123.
// - Requests arriving mid-transfer wait and are arbitrated at unit end.
`timescale 1ns/1ps
`default_nettype none
module dpa_core
	import dpa_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	input wire logic [NUM_EXT-1:0] EXT_XFER_REQ_N,
	input wire logic [1:0] TX_EMPTY_REQ,
	input wire logic [1:0] RX_FULL_REQ,
	input wire logic CAPTURE_REQ,
	input wire logic NMI_EVENT,
	input wire logic ADDR_ERR_EVENT,
	input wire logic UNIT_DONE,
	input wire logic UNIT_LAST,
	output logic GRANT_VALID,
	output logic [1:0] GRANT_CHAN,
	output logic GRANT_BURST,
	output logic [3:0] CHAN_RUN_OK
);
	dpa_chan_ctrl_type chan_ctrl [NUM_CHAN];
	dpa_oper_type oper;
	dpa_pren_type pren;
	dpa_state_type state;
	logic [1:0] rr_top;
	logic [NUM_EXT-1:0] ext_lvl;
	logic [NUM_EXT-1:0] ext_prev;
	logic [NUM_EXT-1:0] ext_pend;
	logic [NUM_EXT-1:0] ext_fall;
	logic [NUM_EXT-1:0] ext_accept;
	logic [NUM_EXT-1:0] ext_req;
	logic [NUM_PSRC-1:0] periph_pend;
	logic [NUM_PSRC-1:0] periph_in;
	logic [NUM_PSRC-1:0] periph_en;
	logic [NUM_PSRC-1:0] periph_serve;
	logic [3:0] chan_ok;
	logic [3:0] chan_req;
	logic [3:0] eff_burst;
	logic win_valid;
	logic [1:0] win_chan;
	logic unit_end;
	logic others_req;
	logic [3:0] g_src;
	logic aw_got;
	logic w_got;
	logic [AXI_AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_do;
	logic [31:0] rd_word;
	logic rd_hit;
	logic wr_hit;

	// Pin synchronisers
	for (genvar e = 0; e < NUM_EXT; e++) begin : g_ext
		dpa_pin_sync u_dpa_pin_sync (
			.clk(CLK_SYS),
			.reset_n(RESET_N),
			.pin(EXT_XFER_REQ_N[e]),
			.level(ext_lvl[e])
		);
	end

	// Per-channel enable condition and request selection
	always_comb begin
		for (int c = 0; c < NUM_CHAN; c++) begin
			chan_ok[c] = chan_ctrl[c].chan_enable && oper.master_enable &&
				!chan_ctrl[c].xfer_end_flag && !oper.nmi_flag &&
				!oper.addr_err_flag;
			eff_burst[c] = chan_ctrl[c].burst_mode &&
				!is_serial(chan_ctrl[c].req_source_sel);
			chan_req[c] = 1'b0;
			if (is_ext(chan_ctrl[c].req_source_sel) && c < NUM_EXT)
				chan_req[c] = ext_req[c[0]];
			else if (chan_ctrl[c].req_source_sel == SRC_AUTO)
				chan_req[c] = 1'b1;
			else if (is_serial(chan_ctrl[c].req_source_sel))
				chan_req[c] = periph_pend[chan_ctrl[c].req_source_sel[1:0]];
			else if (is_capture(chan_ctrl[c].req_source_sel))
				chan_req[c] = periph_pend[PSRC_CAP];
			chan_req[c] = chan_req[c] && chan_ok[c];
		end
	end
	assign CHAN_RUN_OK = chan_ok;

	// External request detection
	always_comb begin
		for (int e = 0; e < NUM_EXT; e++) begin
			ext_accept[e] = !chan_ctrl[e].xfer_end_flag && !oper.nmi_flag &&
				!oper.addr_err_flag;
			ext_fall[e] = ext_prev[e] && !ext_lvl[e];
			ext_req[e] = chan_ctrl[e].req_detect_sel ? ext_pend[e] :
				!ext_lvl[e];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N)
			ext_prev <= '1;
		else
			ext_prev <= ext_lvl;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			ext_pend <= '0;
		end else begin
			for (int e = 0; e < NUM_EXT; e++) begin
				if (!ext_accept[e] || !chan_ctrl[e].req_detect_sel)
					ext_pend[e] <= 1'b0;
				else if (ext_fall[e])
					ext_pend[e] <= 1'b1;
				else if (unit_end && GRANT_CHAN == 2'(e))
					ext_pend[e] <= 1'b0;
			end
		end
	end

	// Peripheral request latches
	assign periph_in = {CAPTURE_REQ, RX_FULL_REQ[1], TX_EMPTY_REQ[1],
		RX_FULL_REQ[0], TX_EMPTY_REQ[0]};
	assign periph_en = {pren.capture_req_en_hi || pren.capture_req_en_lo,
		pren.serial_en};
	assign g_src = chan_ctrl[GRANT_CHAN].req_source_sel;

	always_comb begin
		periph_serve = '0;
		if (unit_end && (!eff_burst[GRANT_CHAN] || UNIT_LAST)) begin
			if (is_serial(g_src))
				periph_serve[g_src[1:0]] = 1'b1;
			else if (is_capture(g_src))
				periph_serve[PSRC_CAP] = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			periph_pend <= '0;
		end else begin
			for (int p = 0; p < NUM_PSRC; p++) begin
				if (!periph_en[p])
					periph_pend[p] <= 1'b0;
				else if (periph_in[p])
					periph_pend[p] <= 1'b1;
				else if (periph_serve[p])
					periph_pend[p] <= 1'b0;
			end
		end
	end

	// Arbitration and grant
	dpa_arbiter u_dpa_arbiter (
		.req(chan_req),
		.prio_sel(oper.prio_sel),
		.rr_top(rr_top),
		.win_valid(win_valid),
		.win_chan(win_chan)
	);

	assign unit_end = (state == ST_BUSY) && UNIT_DONE;
	assign others_req = |(chan_req & ~(4'h1 << GRANT_CHAN));
	assign GRANT_VALID = (state == ST_BUSY);

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			state <= ST_IDLE;
			GRANT_CHAN <= 2'h0;
			GRANT_BURST <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (win_valid) begin
						state <= ST_BUSY;
						GRANT_CHAN <= win_chan;
						GRANT_BURST <= eff_burst[win_chan];
					end
				end
				ST_BUSY: begin
					// Burst keeps the bus; otherwise rearbitrate at unit end
					if (UNIT_DONE && !(GRANT_BURST && !UNIT_LAST &&
						chan_ok[GRANT_CHAN]))
						state <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N)
			rr_top <= RR_TOP_RST;
		else if (unit_end && oper.prio_sel == PRIO_RR) begin
			if (others_req)
				rr_top <= 2'(GRANT_CHAN + 2'h1);
			else
				rr_top <= RR_TOP_RST;
		end
	end

	// AXI4-Lite slave
	assign S_AXI_AWREADY = !aw_got;
	assign S_AXI_WREADY = !w_got;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign wr_do = aw_got && w_got && !S_AXI_BVALID;
	assign wr_hit = (aw_addr[1:0] == 2'h0) && (aw_addr <= OFS_PREN);

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			aw_got <= 1'b0;
			aw_addr <= '0;
		end else if (S_AXI_AWVALID && !aw_got) begin
			aw_got <= 1'b1;
			aw_addr <= S_AXI_AWADDR;
		end else if (wr_do) begin
			aw_got <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			w_got <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (S_AXI_WVALID && !w_got) begin
			w_got <= 1'b1;
			w_data <= S_AXI_WDATA;
			w_strb <= S_AXI_WSTRB;
		end else if (wr_do) begin
			w_got <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else if (wr_do) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// Channel control: hardware setting of end flag wins over software
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			for (int c = 0; c < NUM_CHAN; c++)
				chan_ctrl[c] <= CHAN_CTRL_RST;
		end else begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				if (wr_do && w_strb[0] && aw_addr == OFS_CHAN0 + 8'(4 * c))
					chan_ctrl[c] <= w_data[7:0];
				if (unit_end && UNIT_LAST && GRANT_CHAN == 2'(c))
					chan_ctrl[c].xfer_end_flag <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			oper <= OPER_RST;
		end else begin
			if (wr_do && aw_addr == OFS_OPER) begin
				if (w_strb[0]) begin
					oper.master_enable <= w_data[OPER_ME_BIT];
					oper.nmi_flag <= w_data[OPER_NMI_BIT];
					oper.addr_err_flag <= w_data[OPER_AE_BIT];
				end
				if (w_strb[1])
					oper.prio_sel <= w_data[OPER_PRIO_LSB +: 2];
			end
			if (NMI_EVENT)
				oper.nmi_flag <= 1'b1;
			if (ADDR_ERR_EVENT)
				oper.addr_err_flag <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N)
			pren <= PREN_RST;
		else if (wr_do && w_strb[0] && aw_addr == OFS_PREN)
			pren <= w_data[5:0];
	end

	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		unique case (S_AXI_ARADDR)
			OFS_CHAN0: rd_word[7:0] = chan_ctrl[0];
			OFS_CHAN1: rd_word[7:0] = chan_ctrl[1];
			OFS_CHAN2: rd_word[7:0] = chan_ctrl[2];
			OFS_CHAN3: rd_word[7:0] = chan_ctrl[3];
			OFS_OPER: begin
				rd_word[OPER_ME_BIT] = oper.master_enable;
				rd_word[OPER_NMI_BIT] = oper.nmi_flag;
				rd_word[OPER_AE_BIT] = oper.addr_err_flag;
				rd_word[OPER_PRIO_LSB +: 2] = oper.prio_sel;
			end
			OFS_STAT: rd_word[16:0] = {ext_pend, periph_pend, rr_top,
				1'b0, GRANT_CHAN, GRANT_VALID, chan_req};
			OFS_PREN: rd_word[5:0] = pren;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= RESP_OKAY;
		end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_word;
			S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// Checks
	sequence s_unit_end;
		GRANT_VALID && UNIT_DONE;
	endsequence

	property p_win_enabled;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		win_valid |-> chan_ok[win_chan];
	endproperty
	a_win_enabled: assert property (p_win_enabled)
		else $error("winner channel not enabled");

	property p_grant;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		(!GRANT_VALID && win_valid) |=>
			GRANT_VALID && GRANT_CHAN == $past(win_chan);
	endproperty
	a_grant: assert property (p_grant)
		else $error("grant does not follow winner");

	property p_fix_order;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		win_valid && ((oper.prio_sel == PRIO_FIX0 && chan_req[0]) ||
			(oper.prio_sel == PRIO_FIX1 && chan_req[0]) ||
			(oper.prio_sel == PRIO_FIX2 && chan_req[2])) |->
			win_chan == (oper.prio_sel == PRIO_FIX2 ? 2'h2 : 2'h0);
	endproperty
	a_fix_order: assert property (p_fix_order)
		else $error("fixed order top channel lost");

	property p_fix1_last;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		win_valid && oper.prio_sel == PRIO_FIX1 && win_chan == 2'h1 |->
			chan_req == 4'h2;
	endproperty
	a_fix1_last: assert property (p_fix1_last)
		else $error("channel 1 won without being alone");

	property p_rr_rotate;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		s_unit_end and (oper.prio_sel == PRIO_RR && others_req) |=>
			rr_top == 2'($past(GRANT_CHAN) + 2'h1);
	endproperty
	a_rr_rotate: assert property (p_rr_rotate)
		else $error("round robin did not rotate");

	property p_rr_idle_reset;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		s_unit_end and (oper.prio_sel == PRIO_RR && !others_req) |=>
			rr_top == RR_TOP_RST;
	endproperty
	a_rr_idle_reset: assert property (p_rr_idle_reset)
		else $error("round robin order not restored");

	property p_hold;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		GRANT_VALID && !UNIT_DONE |=> GRANT_VALID && $stable(GRANT_CHAN);
	endproperty
	a_hold: assert property (p_hold)
		else $error("grant changed mid unit");

	property p_cap_withdraw;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!pren.capture_req_en_hi && !pren.capture_req_en_lo |=>
			!periph_pend[PSRC_CAP];
	endproperty
	a_cap_withdraw: assert property (p_cap_withdraw)
		else $error("capture request not withdrawn");

	property p_edge_latch;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		chan_ctrl[0].req_detect_sel && ext_fall[0] && ext_accept[0] ##1
			chan_ctrl[0].req_detect_sel && ext_accept[0] |-> ext_pend[0];
	endproperty
	a_edge_latch: assert property (p_edge_latch)
		else $error("edge request not held");

	property p_serial_steal;
		@(posedge CLK_SYS) disable iff (!RESET_N)
		GRANT_VALID && is_serial(g_src) |-> !GRANT_BURST;
	endproperty
	a_serial_steal: assert property (p_serial_steal)
		else $error("serial source granted in burst");
endmodule : dpa_core
`default_nettype wire

//--- sim/dpa_far_model.sv
// Far-side model: external requesters and the transfer engine
`timescale 1ns/1ps
`default_nettype none
module dpa_far_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [1:0] ext_req,
	input wire logic [3:0] dly,
	input wire logic grant_valid,
	input wire logic grant_burst,
	output logic [1:0] ext_xfer_req_n,
	output logic unit_done,
	output logic unit_last
);
	logic [3:0] cnt;
	logic [2:0] units;
	// Request pins idle high, also throughout reset
	assign ext_xfer_req_n = reset_n ? ~ext_req : 2'h3;
	// A burst ends on its third unit
	assign unit_last = unit_done && grant_burst && (units == 3'h3);
	always_ff @(posedge clk) begin
		if (!reset_n || !grant_valid) begin
			cnt <= 4'h0;
			units <= 3'h0;
			unit_done <= 1'b0;
		end else if (unit_done || cnt < dly) begin
			cnt <= cnt + 4'h1;
			unit_done <= 1'b0;
		end else begin
			cnt <= 4'h0;
			units <= units + 3'h1;
			unit_done <= 1'b1;
		end
	end
endmodule : dpa_far_model
`default_nettype wire

//--- sim/dma_request_priority_arbiter_bench.sv
// Self-checking bench for the DMA request priority arbiter
`timescale 1ns/1ps
`default_nettype none
module dma_request_priority_arbiter_bench import dpa_pkg::*; ;
	localparam logic [7:0] ORD [4] = '{8'he4, 8'h78, 8'hd2, 8'he4};
	logic clk, rst_n, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
	logic cap, nmi, aerr, udone, ulast, gv, gb, gv_d;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd;
	logic [3:0] ws, runok, dly;
	logic [1:0] bresp, rresp, ext_n, ext, tx, rx, gch;
	logic [15:0] rnd;
	logic [2:0] exp_g[$];
	logic [33:0] exp_r[$];
	int errors, comparisons;

	dpa_core u_dpa_core (.CLK_SYS(clk), .RESET_N(rst_n),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(ws), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
		.S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .EXT_XFER_REQ_N(ext_n),
		.TX_EMPTY_REQ(tx), .RX_FULL_REQ(rx), .CAPTURE_REQ(cap),
		.NMI_EVENT(nmi), .ADDR_ERR_EVENT(aerr), .UNIT_DONE(udone),
		.UNIT_LAST(ulast), .GRANT_VALID(gv), .GRANT_CHAN(gch),
		.GRANT_BURST(gb), .CHAN_RUN_OK(runok));
	dpa_far_model u_dpa_far_model (.clk(clk), .reset_n(rst_n),
		.ext_req(ext), .dly(dly), .grant_valid(gv), .grant_burst(gb),
		.ext_xfer_req_n(ext_n), .unit_done(udone), .unit_last(ulast));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input string what, input logic [33:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("Comparisons %0d, errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	function automatic logic [31:0] cc(input logic en, bm, ds,
		input logic [3:0] s);
		cc = {24'h0, 1'b0, en, bm, ds, s};
	endfunction : cc

	function automatic logic [31:0] op(input logic me, input logic [1:0] p);
		op = {22'h0, p, 7'h0, me};
	endfunction : op

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		exp_r.push_back({er, 32'h0});
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		while (pa || pw) begin
			@(negedge clk);
			ta = pa && awr;
			tw = pw && wrd;
			@(posedge clk);
			if (ta)
				awv <= 1'b0;
			if (tw)
				wv <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do @(negedge clk); while (bv !== 1'b1);
		@(posedge clk);
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta;
		exp_r.push_back({er, d});
		arv <= 1'b1;
		ara <= a;
		do begin
			@(negedge clk);
			ta = arr;
			@(posedge clk);
		end while (!ta);
		arv <= 1'b0;
		do @(negedge clk); while (rv !== 1'b1);
		@(posedge clk);
	endtask : axr

	// Channel bits map to tx a, rx a, tx fifo, rx fifo
	task automatic pulse(input logic [3:0] c, input logic k);
		tx <= {c[2], c[0]};
		rx <= {c[3], c[1]};
		cap <= k;
		@(posedge clk);
		tx <= 2'h0;
		rx <= 2'h0;
		cap <= 1'b0;
	endtask : pulse

	task automatic wait_gv(input logic v);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (gv !== v && n < 100);
		check("grant wait", 34'(gv), 34'(v));
		@(posedge clk);
	endtask : wait_gv

	task automatic settle();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((exp_g.size() != 0 || gv) && n < 400);
		repeat (12) @(negedge clk);
		@(posedge clk);
		check("grants left", 34'(exp_g.size()), 34'h0);
	endtask : settle

	// Results are compared in the order they were noted
	always @(negedge clk) begin
		if (rv && rr)
			check("read", {rresp, rd}, exp_r.pop_front());
		if (bv && br)
			check("write", {bresp, 32'h0}, exp_r.pop_front());
		if (gv && !gv_d)
			check("grant", {31'h0, gb, gch}, exp_g.size() ?
				34'(exp_g.pop_front()) : 34'h8);
		gv_d = gv;
	end

	initial begin
		#(30000 * 100);
		errors++;
		end_of_test();
	end

	initial begin
		errors = 0;
		comparisons = 0;
		gv_d = 1'b0;
		rst_n = 1'b0;
		{awv, wv, arv, cap, nmi, aerr} = 6'h0;
		{br, rr} = 2'h3;
		{awa, ara, wd, ws} = {16'h0, 32'h0, 4'hf};
		{tx, rx, ext, dly} = 10'h0;
		rnd = 16'h0019;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		axr(OFS_OPER, 32'h0, RESP_OKAY);
		axr(OFS_PREN, 32'h0, RESP_OKAY);
		rnd = lfsr(rnd);
		axw(8'h1c, {rnd, rnd}, RESP_SLVERR);
		axr(8'h1c, 32'h0, RESP_SLVERR);
		axw(OFS_STAT, {rnd, rnd}, RESP_OKAY);
		axr(OFS_STAT, 32'h0, RESP_OKAY);
		axw(OFS_PREN, {rnd, rnd}, RESP_OKAY);
		axr(OFS_PREN, {26'h0, rnd[5:0]}, RESP_OKAY);
		// Serial sources on all channels, cycle steal only
		axw(OFS_PREN, 32'hf, RESP_OKAY);
		for (int i = 0; i < 4; i++)
			axw(8'(i * 4), cc(1'b1, 1'b0, 1'b0, 4'(8 + i)), RESP_OKAY);
		for (int m = 0; m < 4; m++) begin
			rnd = lfsr(rnd);
			dly <= {1'b0, rnd[2:0]};
			axw(OFS_OPER, op(1'b0, 2'(m)), RESP_OKAY);
			pulse(4'hf, 1'b0);
			for (int r = 0; r < 4; r++)
				exp_g.push_back({1'b0, ORD[m][2 * r +: 2]});
			axw(OFS_OPER, op(1'b1, 2'(m)), RESP_OKAY);
			settle();
			check("run ok", 34'(runok), 34'hf);
		end
		// Round robin with requests arriving mid-transfer
		dly <= 4'h6;
		exp_g = '{3'h0, 3'h1, 3'h3, 3'h0};
		pulse(4'h9, 1'b0);
		wait_gv(1'b1);
		pulse(4'h2, 1'b0);
		wait_gv(1'b0);
		wait_gv(1'b1);
		pulse(4'h1, 1'b0);
		settle();
		axr(OFS_STAT, 32'h0, RESP_OKAY);
		// Capture requests shared by two channels
		axw(OFS_OPER, op(1'b0, PRIO_FIX0), RESP_OKAY);
		axw(OFS_PREN, 32'h0, RESP_OKAY);
		axw(OFS_CHAN0, cc(1'b0, 1'b0, 1'b0, SRC_AUTO), RESP_OKAY);
		axw(OFS_CHAN1, cc(1'b1, 1'b1, 1'b0, 4'hc), RESP_OKAY);
		axw(OFS_CHAN2, cc(1'b1, 1'b1, 1'b0, 4'hd), RESP_OKAY);
		axw(OFS_CHAN3, cc(1'b0, 1'b0, 1'b0, 4'hb), RESP_OKAY);
		axw(OFS_OPER, op(1'b1, PRIO_FIX0), RESP_OKAY);
		pulse(4'hf, 1'b1);
		settle();
		axw(OFS_OPER, op(1'b0, PRIO_FIX0), RESP_OKAY);
		axw(OFS_PREN, 32'h30, RESP_OKAY);
		pulse(4'h0, 1'b1);
		axw(OFS_PREN, 32'h0, RESP_OKAY);
		axw(OFS_OPER, op(1'b1, PRIO_FIX0), RESP_OKAY);
		settle();
		axw(OFS_PREN, 32'h10, RESP_OKAY);
		dly <= 4'h1;
		exp_g.push_back(3'h5);
		pulse(4'h0, 1'b1);
		settle();
		check("run ok", 34'(runok), 34'h4);
		for (int k = 1; k < 3; k++) begin
			axw(OFS_OPER, op(1'b1, PRIO_FIX0), RESP_OKAY);
			{aerr, nmi} <= 2'(k);
			@(posedge clk);
			{aerr, nmi} <= 2'h0;
			@(posedge clk);
			check("run ok", 34'(runok), 34'h0);
			axr(OFS_OPER, 32'(1 + 2 * k), RESP_OKAY);
		end
		// External pin: edge held while disabled, then level, then edge
		axw(OFS_OPER, op(1'b1, PRIO_FIX0), RESP_OKAY);
		axw(OFS_CHAN0, cc(1'b0, 1'b0, 1'b1, SRC_EXT_DUAL), RESP_OKAY);
		ext <= 2'h1;
		repeat (8) @(posedge clk);
		ext <= 2'h0;
		repeat (8) @(posedge clk);
		exp_g.push_back(3'h0);
		axw(OFS_CHAN0, cc(1'b1, 1'b0, 1'b1, SRC_EXT_DUAL), RESP_OKAY);
		settle();
		dly <= 4'h8;
		axw(OFS_CHAN0, cc(1'b1, 1'b0, 1'b0, SRC_EXT_DUAL), RESP_OKAY);
		exp_g.push_back(3'h0);
		ext <= 2'h1;
		wait_gv(1'b1);
		ext <= 2'h0;
		settle();
		axw(OFS_CHAN0, cc(1'b1, 1'b0, 1'b1, SRC_EXT_DUAL), RESP_OKAY);
		dly <= 4'h1;
		exp_g.push_back(3'h0);
		ext <= 2'h1;
		repeat (40) @(posedge clk);
		settle();
		ext <= 2'h0;
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule : dma_request_priority_arbiter_bench
`default_nettype wire
